// ==== prl_pkg.sv ====
package prl_pkg;

	// ****************************************************
	// bus geometry
	// ****************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int MAP_N = 8;
	localparam int MAP_IN_N = 4;
	localparam int MAP_IDX_W = 3;
	localparam int IRQ_N = 4;

	// ****************************************************
	// register offsets (word index on the plain port)
	// ****************************************************
	localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAP_BASE = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h21;

	// ****************************************************
	// oscillator control fields
	// ****************************************************
	localparam int BIT_SWITCH_REQ = 0;
	localparam int BIT_SEC_OSC_EN = 1;
	localparam int BIT_CLK_FAIL = 3;
	localparam int BIT_PIN_MAP_LOCK = 6;
	localparam int NEW_OSC_LSB = 8;
	localparam int CUR_OSC_LSB = 12;
	localparam int OSC_SEL_W = 3;

	// ****************************************************
	// unlock keys
	// ****************************************************
	localparam logic [7:0] KEY_FIRST = 8'h46;
	localparam logic [7:0] KEY_SECOND = 8'h57;

	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic [2:0] CUR_OSC_RST = 3'h0;
	localparam logic [2:0] NEW_OSC_RST = 3'h0;
	localparam logic [15:0] MAP_IN_RST = 16'h1F1F;
	localparam logic [15:0] MAP_OUT_RST = 16'h0000;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;

	// ****************************************************
	// interrupt status bits
	// ****************************************************
	localparam int IRQ_CLK_FAIL = 0;
	localparam int IRQ_MISMATCH = 1;
	localparam int IRQ_KEY_ABORT = 2;
	localparam int IRQ_SWITCH_DONE = 3;

	typedef enum logic [1:0] {
		PRL_UL_IDLE = 2'h0,
		PRL_UL_KEY1 = 2'h1,
		PRL_UL_OPEN = 2'h3
	} prl_unlock_state_t;

endpackage

// ==== prl_unlock.sv ====
`timescale 1ns/100ps
module prl_unlock
	import prl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_n_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic osc_sel_i,
	input wire logic [7:0] key_i,
	output logic open_o,
	output logic abort_o
);

	prl_unlock_state_t state;
	prl_unlock_state_t next_state;
	logic key1_hit;
	logic key2_hit;
	logic any_acc;

	assign key1_hit = wr_i && osc_sel_i && (key_i == KEY_FIRST);
	assign key2_hit = wr_i && osc_sel_i && (key_i == KEY_SECOND);
	assign any_acc = wr_i | rd_i;
	assign open_o = (state == PRL_UL_OPEN);
	// any stray access between the keys kills the sequence
	assign abort_o = (state == PRL_UL_KEY1) && any_acc && !key2_hit;

	always_comb begin
		next_state = state;
		case (state)
			PRL_UL_IDLE: begin
				if (key1_hit) begin
					next_state = PRL_UL_KEY1;
				end
			end
			PRL_UL_KEY1: begin
				if (key2_hit) begin
					next_state = PRL_UL_OPEN;
				end else if (any_acc) begin
					next_state = PRL_UL_IDLE;
				end
			end
			PRL_UL_OPEN: begin
				// window covers one access only
				if (any_acc) begin
					next_state = PRL_UL_IDLE;
				end
			end
			default: begin
				next_state = PRL_UL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= PRL_UL_IDLE;
		end else if (!sys_rst_n_i) begin
			state <= PRL_UL_IDLE;
		end else begin
			state <= next_state;
		end
	end

endmodule

// ==== prl_map_regs.sv ====
`timescale 1ns/100ps
module prl_map_regs
	import prl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_n_i,
	input wire logic wr_i,
	input wire logic [MAP_IDX_W-1:0] idx_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic [MAP_N*DATA_W-1:0] map_o,
	output logic mismatch_o
);

	logic [DATA_W-1:0] map_q [MAP_N];
	logic [DATA_W-1:0] shadow_q [MAP_N];
	logic [MAP_N-1:0] differ;

	genvar i;
	generate
		for (i = 0; i < MAP_N; i++) begin : g_map
			localparam logic [DATA_W-1:0] RST_V =
				(i < MAP_IN_N) ? MAP_IN_RST : MAP_OUT_RST;
			logic hit;
			assign hit = wr_i && (idx_i == MAP_IDX_W'(i));
			// shadow is loaded only by a legal write
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					map_q[i] <= RST_V;
					shadow_q[i] <= RST_V;
				end else if (!sys_rst_n_i) begin
					map_q[i] <= RST_V;
					shadow_q[i] <= RST_V;
				end else if (hit) begin
					map_q[i] <= wdata_i;
					shadow_q[i] <= wdata_i;
				end
			end
			assign differ[i] = (map_q[i] != shadow_q[i]);
			assign map_o[i*DATA_W +: DATA_W] = map_q[i];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mismatch_o <= 1'h0;
		end else begin
			mismatch_o <= |differ;
		end
	end

endmodule

// ==== prl_top.sv ====
// Operation
// - locked mapping register writes are accepted silently but dropped.
// - pin map lock is bit 6 of oscillator control; one blocks map writes.
// - keys 0x46 then 0x57 on low byte, then one write changes lock.
// - lock stays cleared until set again; many map updates per unlock.
// - shadow copies compared constantly; difference raises mismatch reset.
// - single-session option set: once set, lock cannot be cleared until device reset.
// - single-session and locked: unlock has no effect until device reset; unlocked writes still change bits 0, 1, 3 and 10:8.
// - single-session option defaults set; programmed allows many sessions.
// - bit 3 is clock-fail flag, set by fail-safe monitor, software clears.
// - bit 1 enables secondary oscillator; bit 2 reads zero.
// - writing bit 0 requests switch to new source; cleared when complete.
// - oscillator control writes without unlock sequence are ignored.
// - oscillator control resets only on power-on reset; device reset clears lock bit 6.
`timescale 1ns/100ps
module prl_top
	import prl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic single_session_option_i,
	input wire logic fail_safe_monitor_i,
	input wire logic osc_switch_done_i,
	output logic osc_switch_request_o,
	output logic [OSC_SEL_W-1:0] new_osc_select_o,
	output logic secondary_osc_enable_o,
	output logic pin_map_lock_o,
	output logic [MAP_N*DATA_W-1:0] map_regs_o,
	output logic config_mismatch_rst_o,
	output logic irq_o
);

	// ****************************************************
	// address decode
	// ****************************************************
	logic sel_osc;
	logic sel_map;
	logic sel_stat;
	logic sel_mask;
	logic wr_osc;
	logic ul_open;
	logic key_abort;
	logic osc_wr_open;
	logic map_wr;

	assign sel_osc = (addr_i == OFS_OSC_CTRL);
	assign sel_map = (addr_i[ADDR_W-1:MAP_IDX_W] ==
		OFS_MAP_BASE[ADDR_W-1:MAP_IDX_W]);
	assign sel_stat = (addr_i == OFS_IRQ_STATUS);
	assign sel_mask = (addr_i == OFS_IRQ_MASK);
	assign wr_osc = wr_i && sel_osc;
	// only the write right after the second key lands
	assign osc_wr_open = wr_osc && ul_open;

	// ****************************************************
	// unlock sequencer
	// ****************************************************
	prl_unlock u_unlock (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sys_rst_n_i(sys_rst_n_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.osc_sel_i(sel_osc),
		.key_i(wdata_i[7:0]),
		.open_o(ul_open),
		.abort_o(key_abort)
	);

	// ****************************************************
	// single-session option capture
	// ****************************************************
	// a static strap: caught once after reset release, never re-read
	logic ss_taken;
	logic ss_opt;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ss_taken <= 1'h0;
			ss_opt <= 1'h1; // unprogrammed default is set
		end else if (!ss_taken) begin
			ss_taken <= 1'h1;
			ss_opt <= single_session_option_i;
		end
	end

	// ****************************************************
	// pin map lock
	// ****************************************************
	logic lock_q;
	logic lock_once;
	logic lock_set_req;
	logic lock_clr_req;
	logic lock_clr_ok;

	assign lock_set_req = osc_wr_open && wdata_i[BIT_PIN_MAP_LOCK];
	assign lock_clr_req = osc_wr_open && !wdata_i[BIT_PIN_MAP_LOCK];
	// once set under single session, unlock cannot clear it
	assign lock_clr_ok = lock_clr_req && !(ss_opt && lock_once);

	// lock follows the device reset, unlike the rest of the register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_q <= 1'h0;
			lock_once <= 1'h0;
		end else if (!sys_rst_n_i) begin
			lock_q <= 1'h0; // only a reset reopens single session
			lock_once <= 1'h0;
		end else begin
			if (lock_set_req) begin
				lock_q <= 1'h1;
				lock_once <= 1'h1;
			end else if (lock_clr_ok) begin
				lock_q <= 1'h0; // level holds until next write
			end
		end
	end

	// ****************************************************
	// mapping registers
	// ****************************************************
	// locked writes vanish with no error answer
	assign map_wr = wr_i && sel_map && !lock_q;

	logic mismatch;

	prl_map_regs u_map (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sys_rst_n_i(sys_rst_n_i),
		.wr_i(map_wr),
		.idx_i(addr_i[MAP_IDX_W-1:0]),
		.wdata_i(wdata_i),
		.map_o(map_regs_o),
		.mismatch_o(mismatch)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			config_mismatch_rst_o <= 1'h0;
		end else begin
			config_mismatch_rst_o <= mismatch;
		end
	end

	// ****************************************************
	// fail-safe monitor input synchroniser
	// ****************************************************
	logic cf_s1;
	logic cf_s2;
	logic cf_s3;
	logic cf_lvl;
	logic cf_agree;
	logic cf_rise;

	// first stage may be metastable, so only stages two and three vote
	assign cf_agree = (cf_s2 == cf_s3);
	assign cf_rise = cf_agree && cf_s3 && !cf_lvl;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cf_s1 <= 1'h0;
			cf_s2 <= 1'h0;
			cf_s3 <= 1'h0;
			cf_lvl <= 1'h0;
		end else begin
			cf_s1 <= fail_safe_monitor_i;
			cf_s2 <= cf_s1;
			cf_s3 <= cf_s2;
			if (cf_agree) begin
				cf_lvl <= cf_s3;
			end
		end
	end

	// ****************************************************
	// oscillator control register
	// ****************************************************
	// kept through device reset: only the power-on reset clears it
	logic clk_fail;
	logic sec_osc_en;
	logic switch_req;
	logic [OSC_SEL_W-1:0] new_osc;
	logic [OSC_SEL_W-1:0] cur_osc;
	logic switch_done;
	logic next_clk_fail;
	logic next_switch_req;

	assign switch_done = switch_req && osc_switch_done_i;
	// monitor event beats a software clear in the same cycle
	assign next_clk_fail = cf_rise ||
		(clk_fail && !(osc_wr_open && !wdata_i[BIT_CLK_FAIL]));
	// a new request written in the done cycle is kept
	assign next_switch_req = (osc_wr_open && wdata_i[BIT_SWITCH_REQ]) ||
		(switch_req && !osc_switch_done_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_fail <= 1'h0;
			sec_osc_en <= 1'h0;
			switch_req <= 1'h0;
			new_osc <= NEW_OSC_RST;
			cur_osc <= CUR_OSC_RST;
		end else begin
			clk_fail <= next_clk_fail;
			switch_req <= next_switch_req;
			if (switch_done) begin
				cur_osc <= new_osc;
			end
			if (osc_wr_open) begin
				sec_osc_en <= wdata_i[BIT_SEC_OSC_EN];
				// source legality between PLL modes is software's
				new_osc <= wdata_i[NEW_OSC_LSB +: OSC_SEL_W];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_switch_request_o <= 1'h0;
			new_osc_select_o <= NEW_OSC_RST;
			secondary_osc_enable_o <= 1'h0;
			pin_map_lock_o <= 1'h0;
		end else begin
			osc_switch_request_o <= next_switch_req;
			new_osc_select_o <= osc_wr_open ?
				wdata_i[NEW_OSC_LSB +: OSC_SEL_W] : new_osc;
			secondary_osc_enable_o <= osc_wr_open ?
				wdata_i[BIT_SEC_OSC_EN] : sec_osc_en;
			pin_map_lock_o <= !sys_rst_n_i ? 1'h0 :
				(lock_set_req | (lock_q & !lock_clr_ok));
		end
	end

	// ****************************************************
	// interrupt status and mask
	// ****************************************************
	logic [IRQ_N-1:0] irq_stat;
	logic [IRQ_N-1:0] irq_mask;
	logic [IRQ_N-1:0] irq_evt;
	logic [IRQ_N-1:0] irq_clr;
	logic [IRQ_N-1:0] next_irq_stat;

	assign irq_evt[IRQ_CLK_FAIL] = cf_rise;
	assign irq_evt[IRQ_MISMATCH] = mismatch && !config_mismatch_rst_o;
	assign irq_evt[IRQ_KEY_ABORT] = key_abort;
	assign irq_evt[IRQ_SWITCH_DONE] = switch_done;
	assign irq_clr = (wr_i && sel_stat) ? wdata_i[IRQ_N-1:0] : '0;
	// set beats the write-one clear
	assign next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_stat <= '0;
			irq_mask <= IRQ_MASK_RST;
			irq_o <= 1'h0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr_i && sel_mask) begin
				irq_mask <= wdata_i[IRQ_N-1:0];
			end
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// ****************************************************
	// read path
	// ****************************************************
	logic [DATA_W-1:0] osc_rd;
	logic [DATA_W-1:0] map_rd;
	logic [DATA_W-1:0] rd_mux;

	// bit 2, bit 7 and the gaps read as zero
	assign osc_rd = {1'h0, cur_osc, 1'h0, new_osc, 1'h0, lock_q,
		2'h0, clk_fail, 1'h0, sec_osc_en, switch_req};
	// reads clear no status (only a write does) but do break the unlock sequence
	assign map_rd = map_regs_o[addr_i[MAP_IDX_W-1:0]*DATA_W +: DATA_W];
	assign rd_mux = sel_osc ? osc_rd :
		sel_map ? map_rd :
		sel_stat ? {{(DATA_W-IRQ_N){1'h0}}, irq_stat} :
		sel_mask ? {{(DATA_W-IRQ_N){1'h0}}, irq_mask} :
		'0;

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= rd_i ? rd_mux : '0;
		end
	end

endmodule

// ==== prl_chk.sv ====
`timescale 1ns/100ps
module prl_chk
	import prl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sys_rst_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic single_session_option_i,
	input wire logic osc_switch_done_i,
	input wire logic osc_switch_request_o,
	input wire logic secondary_osc_enable_o,
	input wire logic pin_map_lock_o,
	input wire logic [MAP_N*DATA_W-1:0] map_regs_o,
	input wire logic config_mismatch_rst_o
);
	// ****
	// helpers
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire osc_w = wr_i && addr_i == OFS_OSC_CTRL && sys_rst_n_i;
	wire map_w = wr_i && addr_i[7:3] == OFS_MAP_BASE[7:3] && sys_rst_n_i;
	wire key2_w = osc_w && wdata_i[7:0] == KEY_SECOND;
	wire [2:0] idx_w = addr_i[2:0];
	sequence keys_s;
		osc_w && wdata_i[7:0] == KEY_FIRST ##1 key2_w;
	endsequence
	// ****
	// assertions
	// ****
	lock_set_a: assert property (keys_s ##1 (osc_w && wdata_i[6])
		|=> pin_map_lock_o) else $error("lock not set");
	lock_clear_a: assert property (keys_s
		##1 (osc_w && !wdata_i[6] && !single_session_option_i)
		|=> !pin_map_lock_o) else $error("lock not cleared");
	osc_guard_a: assert property ($changed(secondary_osc_enable_o)
		|-> $past(osc_w) && $past(key2_w, 2))
		else $error("osc control changed without keys");
	map_hold_a: assert property (pin_map_lock_o && map_w
		|=> $stable(map_regs_o)) else $error("locked map changed");
	map_write_a: assert property (!pin_map_lock_o && map_w
		|=> map_regs_o[16*$past(idx_w) +: 16] == $past(wdata_i))
		else $error("map write lost");
	one_session_a: assert property (pin_map_lock_o
		&& single_session_option_i && sys_rst_n_i |=> pin_map_lock_o)
		else $error("single session lock cleared");
	osc_read_a: assert property (rd_i
		&& addr_i == OFS_OSC_CTRL && sys_rst_n_i
		|=> rdata_o[2] == 1'h0 && rdata_o[6] == pin_map_lock_o
		&& rdata_o[1] == secondary_osc_enable_o) else $error("osc read bad");
	switch_end_a: assert property (osc_switch_request_o
		&& osc_switch_done_i |=> !osc_switch_request_o)
		else $error("switch request stuck");
	shadow_ok_a: assert property (!config_mismatch_rst_o)
		else $error("spurious mismatch reset");
endmodule

bind prl_top prl_chk chk_u (.clk_i, .rst_n_i, .sys_rst_n_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .single_session_option_i,
	.osc_switch_done_i, .osc_switch_request_o, .secondary_osc_enable_o,
	.pin_map_lock_o, .map_regs_o, .config_mismatch_rst_o);

// ==== pin_remap_config_lock_tb.sv ====
`timescale 1ns/100ps
module pin_remap_config_lock_tb
	import prl_pkg::*;
;
	localparam logic [7:0] OC = OFS_OSC_CTRL;
	logic clk_i, rst_n_i, sys_rst_n_i, wr_i, rd_i, strap, fmon, sdone;
	logic [7:0] addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic req, sec, lock, mism, irq;
	logic [2:0] new_osc_select;
	logic [127:0] maps;
	int err_total, total_checks, cyc;

	prl_top dut_u (.clk_i, .rst_n_i, .sys_rst_n_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .single_session_option_i(strap),
		.fail_safe_monitor_i(fmon), .osc_switch_done_i(sdone),
		.osc_switch_request_o(req), .new_osc_select_o(new_osc_select),
		.secondary_osc_enable_o(sec), .pin_map_lock_o(lock),
		.map_regs_o(maps), .config_mismatch_rst_o(mism), .irq_o(irq));

	initial begin
		clk_i = 1'h0;
		forever #50 clk_i = ~clk_i;
	end
	// ****
	// bus tasks
	// ****
	task automatic chk(input string n, input logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// strobe left high so back-to-back writes need no gap
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		rd_i <= 1'h0;
	endtask
	task idle;
		@(posedge clk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h0;
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i);
		addr_i <= a;
		wr_i <= 1'h0;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		@(negedge clk_i);
		chk("rdata", rdata_o, e);
	endtask
	task automatic osc(input logic [15:0] d);
		wr(OC, 16'h0046);
		wr(OC, 16'h0057);
		wr(OC, d);
		idle();
	endtask
	task automatic por(input logic s);
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		strap <= s;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'h1;
	endtask
	task srst;
		@(posedge clk_i);
		sys_rst_n_i <= 1'h0;
		@(posedge clk_i);
		sys_rst_n_i <= 1'h1;
		@(negedge clk_i);
	endtask
	// a hang in a bounded wait ends the run here
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			conclude();
		end
	end
	// ****
	// sequence
	// ****
	initial begin
		{rst_n_i, wr_i, rd_i, strap, fmon, sdone} = 6'h00;
		sys_rst_n_i = 1'h1;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		err_total = 0;
		total_checks = 0;
		cyc = 0;
		por(1'h0);
		rd(OC, 16'h0000);
		wr(OC, 16'h0002);
		idle();
		rd(OC, 16'h0000);
		osc(16'h0040);
		rd(OC, 16'h0040);
		wr(8'h12, 16'h0505);
		idle();
		rd(8'h12, MAP_IN_RST);
		osc(16'h0000);
		wr(8'h12, 16'h0505);
		wr(8'h15, 16'h0A0A);
		idle();
		chk("map2", maps[47:32], 16'h0505);
		rd(8'h15, 16'h0A0A);
		wr(OC, 16'h0046);
		rd(8'h30, 16'h0000);
		wr(OC, 16'h0057);
		wr(OC, 16'h0042);
		wr(OC, 16'h0046);
		wr(OC, 16'h0057);
		rd(OC, 16'h0000);
		wr(OC, 16'h0042);
		idle();
		rd(OC, 16'h0000);
		osc(16'h0006);
		rd(OC, 16'h0002);
		chk("sec", 16'(sec), 16'h0001);
		osc(16'h0303);
		chk("req", 16'(req), 16'h0001);
		chk("new_osc_select", 16'(new_osc_select), 16'h0003);
		@(posedge clk_i);
		sdone <= 1'h1;
		@(posedge clk_i);
		sdone <= 1'h0;
		@(negedge clk_i);
		chk("req", 16'(req), 16'h0000);
		rd(OC, 16'h3302);
		rd(8'h20, 16'h000C);
		chk("irq", 16'(irq), 16'h0000);
		wr(8'h21, 16'h0008);
		idle();
		@(negedge clk_i);
		chk("irq", 16'(irq), 16'h0001);
		wr(8'h20, 16'h000C);
		idle();
		@(negedge clk_i);
		chk("irq", 16'(irq), 16'h0000);
		@(posedge clk_i);
		fmon <= 1'h1;
		repeat (8) @(posedge clk_i);
		fmon <= 1'h0;
		rd(OC, 16'h330A);
		rd(8'h20, 16'h0001);
		osc(16'h0302);
		rd(OC, 16'h3302);
		srst();
		rd(OC, 16'h3302);
		rd(8'h15, MAP_OUT_RST);
		por(1'h1);
		osc(16'h0040);
		osc(16'h0000);
		rd(OC, 16'h0040);
		wr(8'h12, 16'h0505);
		idle();
		rd(8'h12, MAP_IN_RST);
		srst();
		chk("lock", 16'(lock), 16'h0000);
		chk("mism", 16'(mism), 16'h0000);
		conclude();
	end
endmodule
